// ==== eeprom_port_params.svh ====
// Purpose: Constants shared by both ends of the byte EEPROM bus port
// Assumes: 200 MHz system clock, 5 ns period
// Notes:   Times are kept in their printed unit; cycle counts derive from them
`ifndef EEPROM_PORT_PARAMS_SVH
`define EEPROM_PORT_PARAMS_SVH

`define ADDR_W              7
`define DATA_W              8
`define CLK_PERIOD_PS       5000
// Status delay after program start, longest 150 ns
`define STATUS_DELAY_NS     150
`define STATUS_DELAY_CYC    ((`STATUS_DELAY_NS * 1000) / `CLK_PERIOD_PS)
// Programming interval bounds in ms
`define PROG_MIN_MS         20
`define PROG_MAX_MS         100
// Program clock rate bounds in kHz
`define PROG_CLK_MIN_KHZ    10
`define PROG_CLK_MAX_KHZ    50
// Program clock periods per programming interval: 1000 periods gives
// 20 ms at 50 kHz and 100 ms at 10 kHz
`define PROG_TICKS          ((`PROG_MIN_MS * `PROG_CLK_MAX_KHZ))
// Write strobe low pulse bounds in ns
`define WE_MIN_NS           100
`define WE_MAX_NS           10000
`define WE_MIN_CYC          (((`WE_MIN_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WE_MAX_CYC          ((`WE_MAX_NS * 1000) / `CLK_PERIOD_PS)
// Setup and hold around strobes used by the host, in cycles
`define HOST_SETUP_CYC      4
// Host program clock half period for 50 kHz at 200 MHz
`define PCLK_HALF_CYC       ((1000000000 / (`PROG_CLK_MAX_KHZ * 1000)) / (2 * `CLK_PERIOD_PS / 1000))

`endif

// ==== eeprom_port_pkg.sv ====
// Purpose: Types shared by both ends of the byte EEPROM bus port
// Assumes: Constants come from eeprom_port_params.svh
// Notes:   Holds types only
`include "eeprom_port_params.svh"
package eeprom_port_pkg;
  typedef logic [`ADDR_W-1:0] byte_addr_t;  // Byte address
  typedef logic [`DATA_W-1:0] byte_data_t;  // Data byte
  typedef enum logic [1:0]
  {
    MODE_STANDBY = 2'b00,
    MODE_READ    = 2'b01,
    MODE_PROGRAM = 2'b10
  } port_mode_t;
endpackage

// ==== eeprom_port_if.sv ====
// Purpose: Pin bundle between host and byte EEPROM
// Assumes: One system clock; shared bus resolved here from enables
// Notes:   In multiplexed use the address pins are fed from the data bus
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_port_params.svh"
interface eeprom_port_if
  import eeprom_port_pkg::*;
  (
    input wire logic sys_clk
  );
  logic       chip_sel_n;          // Chip select, active low
  logic       out_gate_n;          // Output gate, active low
  logic       write_strobe_n;      // Write strobe, active low
  logic       addr_latch;          // Address latch strobe, falling edge latches
  logic       muxed;               // High when address travels on the data bus
  byte_addr_t byte_address_lines;  // Separate address pins from the host
  byte_data_t host_data_out;       // Host drive onto data lines
  logic       host_data_oe;        // Host drives data lines
  byte_data_t mem_data_out;        // Memory drive onto data lines
  logic       mem_data_oe;         // Memory drives data lines
  logic       ready_busy;          // High ready, low while programming
  logic       program_clock;       // Slow program clock
  byte_data_t byte_data_lines;     // Resolved data bus level
  byte_addr_t addr_seen;           // Address as the memory sees it

  // Resolve the data bus; undriven bus reads as all ones
  assign byte_data_lines = mem_data_oe ? mem_data_out : (host_data_oe ? host_data_out : 8'hff);
  assign addr_seen       = muxed ? byte_data_lines[`ADDR_W-1:0] : byte_address_lines;

  modport memory
  (
    input  chip_sel_n, out_gate_n, write_strobe_n, addr_latch, muxed,
    input  addr_seen, byte_data_lines, program_clock,
    output mem_data_out, mem_data_oe, ready_busy
  );
  modport host
  (
    output chip_sel_n, out_gate_n, write_strobe_n, addr_latch, muxed,
    output byte_address_lines, host_data_out, host_data_oe, program_clock,
    input  byte_data_lines, ready_busy
  );
endinterface
`default_nettype wire

// ==== eeprom_memory_end.sv ====
// Purpose: Memory end of the byte EEPROM port: 128 x 8 array, latches, self-timed program
// Assumes: All pins come from outside the clock domain and pass two flip-flops
// Notes:   Separate-line reads follow the address pins after synchronising; multiplexed reads use the address latch
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_port_params.svh"

// How it works
// - Mode from select, gate and strobe pins
// - Data latched on write strobe rising edge
// - Address latched on latch strobe falling edge
// - Host pulses gate in multiplexed mode
// - Host may join strobes with separate lines
// - Host holds address steady for reads
// - Output valid until select, gate, address change
// - Host holds both strobes high reading on separate lines
// - Multiplexed read drives byte until gate rises
// - Separate program: address falling, data rising
// - Status low shortly after start, until done
// - Inputs ignored while programming
// - Program interval twenty to hundred milliseconds
// - Host sends address, then data, then strobe
// - Host write pulse 0.1 to 10 us
// - Interval timed from the program clock
// - Status low when programming, high reading
module eeprom_memory_end
  import eeprom_port_pkg::*;
  #(
    parameter int unsigned PROG_TICKS = `PROG_TICKS  // Program clock periods per interval
  )
  (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    eeprom_port_if.memory  port,
    output logic           prog_busy,       // Programming in progress
    output var port_mode_t mode_now         // Mode decoded from the pins
  );
  import eeprom_port_pkg::*;

  typedef enum logic [1:0]
  {
    PS_IDLE  = 2'b00,
    PS_DELAY = 2'b01,
    PS_PROG  = 2'b10
  } prog_state_t;

  logic [5:0]        ctl_s1_r;        // First sync stage of control pins
  logic [5:0]        ctl_s2_r;        // Second sync stage
  logic [5:0]        ctl_d_r;         // Previous synchronised control levels
  byte_addr_t        addr_s1_r;       // First sync stage of address
  byte_addr_t        addr_s2_r;       // Second sync stage of address
  byte_data_t        data_s1_r;       // First sync stage of data
  byte_data_t        data_s2_r;       // Second sync stage of data
  byte_addr_t        addr_latch_r;    // Internal address latch
  byte_data_t        data_latch_r;    // Internal data latch
  byte_data_t        mem_r [0:(1<<`ADDR_W)-1];  // Storage array
  byte_data_t        rd_data_r;       // Output byte
  logic              rd_oe_r;         // Output enable
  logic              ready_r;         // Ready/busy status
  prog_state_t       pstate_r;        // Programming sequencer
  logic [7:0]        dly_cnt_r;       // Status delay counter
  logic [15:0]       tick_cnt_r;      // Program clock period counter
  logic              cs_n, oe_n, we_n, ale, muxed;
  logic              we_rise, ale_fall, pclk_rise, busy;

  // Sync every outside pin through two flops
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctl_s1_r  <= 6'h1f;
      ctl_s2_r  <= 6'h1f;
      ctl_d_r   <= 6'h1f;
      addr_s1_r <= 7'h00;
      addr_s2_r <= 7'h00;
      data_s1_r <= 8'h00;
      data_s2_r <= 8'h00;
    end
    else
    begin
      ctl_s1_r  <= {port.muxed, port.program_clock, port.addr_latch, port.write_strobe_n, port.out_gate_n,
                    port.chip_sel_n};
      ctl_s2_r  <= ctl_s1_r;
      ctl_d_r   <= ctl_s2_r;
      addr_s1_r <= port.addr_seen;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= port.byte_data_lines;
      data_s2_r <= data_s1_r;
    end
  end

  // Muxed flag is synchronised with the other pins so it lines up with the synced address
  assign muxed     = ctl_s2_r[5];
  assign cs_n      = ctl_s2_r[0];
  assign oe_n      = ctl_s2_r[1];
  assign we_n      = ctl_s2_r[2];
  assign ale       = ctl_s2_r[3];
  assign we_rise   = we_n & ~ctl_d_r[2];
  assign ale_fall  = ~ale & ctl_d_r[3];
  assign pclk_rise = ctl_s2_r[4] & ~ctl_d_r[4];
  assign busy      = (pstate_r != PS_IDLE);

  // Pin mode decode
  always_comb
  begin
    if (cs_n)
      mode_now = MODE_STANDBY;
    else if (!oe_n && we_n)
      mode_now = MODE_READ;
    else if (oe_n)
      mode_now = MODE_PROGRAM;
    else
      mode_now = MODE_STANDBY;  // Gate and strobe both low: not a legal mode
  end

  // Address latch on falling latch strobe, frozen while busy
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      addr_latch_r <= 7'h00;
    else if (!busy && !cs_n && ale_fall)
      addr_latch_r <= addr_s2_r;
  end

  // Data latch on rising write strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      data_latch_r <= 8'h00;
    else if (!busy && !cs_n && oe_n && we_rise)
      data_latch_r <= data_s2_r;
  end

  // Programming sequencer: delay, then timed interval on program clock
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pstate_r   <= PS_IDLE;
      dly_cnt_r  <= 8'h00;
      tick_cnt_r <= 16'h0000;
    end
    else
    begin
      unique case (pstate_r)
        PS_IDLE:
        begin
          if (!cs_n && oe_n && we_rise)
          begin
            pstate_r  <= PS_DELAY;
            dly_cnt_r <= 8'h00;
          end
        end
        PS_DELAY:
        begin
          // Status falls 32 cycles after the strobe pin rises, past the 30-cycle longest status delay
          if (dly_cnt_r >= 8'(`STATUS_DELAY_CYC - 3))
          begin
            pstate_r   <= PS_PROG;
            tick_cnt_r <= 16'h0000;
          end
          else
            dly_cnt_r <= dly_cnt_r + 8'h01;
        end
        PS_PROG:
        begin
          // Count program clock periods; 1000 gives 20..100 ms over 50..10 kHz
          if (pclk_rise)
          begin
            if (tick_cnt_r == 16'(PROG_TICKS - 1))
              pstate_r <= PS_IDLE;
            else
              tick_cnt_r <= tick_cnt_r + 16'h0001;
          end
        end
        default:
          pstate_r <= PS_IDLE;
      endcase
    end
  end

  // Array write at the close of the interval
  always_ff @(posedge sys_clk)
  begin
    if (pstate_r == PS_PROG && pclk_rise && tick_cnt_r == 16'(PROG_TICKS - 1))
      mem_r[addr_latch_r] <= data_latch_r;
  end

  // Status: low while programming, high during idle and the status delay
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ready_r <= 1'b1;
    else
      ready_r <= (pstate_r != PS_PROG);
  end

  // Read path: separate lines use live address, muxed uses the latch
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rd_data_r <= 8'h00;
      rd_oe_r   <= 1'b0;
    end
    else if (!busy && mode_now == MODE_READ && we_n && (muxed || ale))
    begin
      rd_data_r <= mem_r[muxed ? addr_latch_r : addr_s2_r];
      rd_oe_r   <= 1'b1;
    end
    else
    begin
      rd_oe_r <= 1'b0;  // Gate or select rose: release the bus
    end
  end

  assign port.mem_data_out = rd_data_r;
  assign port.mem_data_oe  = rd_oe_r;
  assign port.ready_busy   = ready_r;
  assign prog_busy         = busy;
endmodule
`default_nettype wire

// ==== eeprom_host_end.sv ====
// Purpose: Host end: runs read and program cycles on the EEPROM pins
// Assumes: Requests from logic on the same clock; ready pin synchronised
// Notes:   Generates the program clock by division
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_port_params.svh"
module eeprom_host_end
  import eeprom_port_pkg::*;
  #(
    parameter int unsigned WE_CYC = `WE_MIN_CYC * 2  // Write strobe low length
  )
  (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    eeprom_port_if.host     port,
    input wire logic        use_muxed,    // Address on data bus
    input wire logic        req_valid,    // Access request
    input wire logic        req_write,    // High program, low read
    input wire byte_addr_t  req_addr,     // Target address
    input wire byte_data_t  req_data,     // Byte to program
    output logic            req_ready,    // Request accepted this cycle
    output logic            rsp_valid,    // Read byte valid pulse
    output byte_data_t      rsp_data      // Read byte
  );
  import eeprom_port_pkg::*;

  typedef enum logic [2:0]
  {
    HS_IDLE   = 3'b000,
    HS_ALE    = 3'b001,
    HS_SETUP  = 3'b010,
    HS_STROBE = 3'b011,
    HS_READ   = 3'b100,
    HS_WAIT   = 3'b101
  } host_state_t;

  host_state_t hs_r;                 // Sequencer state
  logic [11:0] cnt_r;                // Phase counter
  logic        rdy_s1_r, rdy_s2_r;   // Ready synchroniser
  logic        wr_r;                 // Current access is a program
  byte_addr_t  addr_r;               // Latched request address
  byte_data_t  data_r;               // Latched request byte
  logic [10:0] pdiv_r;               // Program clock divider, wide enough for a 50 kHz half period
  logic        pclk_r;               // Program clock output
  logic        cs_n_r, oe_n_r, we_n_r, ale_r, doe_r;
  byte_data_t  dout_r;

  // Program clock divider
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pdiv_r <= 11'h000;
      pclk_r <= 1'b0;
    end
    else if (pdiv_r == 11'(`PCLK_HALF_CYC - 1))
    begin
      pdiv_r <= 11'h000;
      pclk_r <= ~pclk_r;
    end
    else
      pdiv_r <= pdiv_r + 11'h001;
  end

  // Ready pin synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rdy_s1_r <= 1'b0;
      rdy_s2_r <= 1'b0;
    end
    else
    begin
      rdy_s1_r <= port.ready_busy;
      rdy_s2_r <= rdy_s1_r;
    end
  end

  // Accept only when idle and the device reports ready
  assign req_ready = (hs_r == HS_IDLE) && rdy_s2_r;

  // Access sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      hs_r      <= HS_IDLE;
      cnt_r     <= 12'h000;
      wr_r      <= 1'b0;
      addr_r    <= 7'h00;
      data_r    <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      cs_n_r    <= 1'b1;
      oe_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
      ale_r     <= 1'b1;
      doe_r     <= 1'b0;
      dout_r    <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      cnt_r     <= cnt_r + 12'h001;
      unique case (hs_r)
        HS_IDLE:
        begin
          // Idle: deselected, write strobe and gate high, latch strobe low when multiplexed
          ale_r <= !use_muxed;
          if (req_valid && req_ready)
          begin
            wr_r   <= req_write;
            addr_r <= req_addr;
            data_r <= req_data;
            cs_n_r <= 1'b0;
            oe_n_r <= 1'b1;
            cnt_r  <= 12'h000;
            dout_r <= use_muxed ? {1'b0, req_addr} : req_data;
            doe_r  <= use_muxed || req_write;
            ale_r  <= use_muxed ? 1'b0 : 1'b1;
            hs_r   <= use_muxed ? HS_ALE : (req_write ? HS_STROBE : HS_READ);
          end
        end
        HS_ALE:
        begin
          // Latch strobe high with address on the bus, then fall
          ale_r <= (cnt_r < 12'(`HOST_SETUP_CYC));
          if (cnt_r == 12'(`HOST_SETUP_CYC + 1))
          begin
            dout_r <= data_r;
            doe_r  <= wr_r;         // Read: float address before gating
            cnt_r  <= 12'h000;
            hs_r   <= wr_r ? HS_STROBE : HS_READ;
          end
        end
        HS_STROBE:
        begin
          // Write strobe low for a bounded pulse; joined with latch strobe on separate lines
          we_n_r <= !(cnt_r >= 12'(`HOST_SETUP_CYC) && cnt_r < 12'(`HOST_SETUP_CYC + WE_CYC));
          if (!use_muxed)
            ale_r <= !(cnt_r >= 12'(`HOST_SETUP_CYC) && cnt_r < 12'(`HOST_SETUP_CYC + WE_CYC));
          if (cnt_r == 12'(2 * `HOST_SETUP_CYC + WE_CYC))
          begin
            cs_n_r <= 1'b1;
            doe_r  <= 1'b0;
            cnt_r  <= 12'h000;
            hs_r   <= HS_WAIT;
          end
        end
        HS_READ:
        begin
          // Gate pulsed low, then sample after pipeline settles
          oe_n_r <= (cnt_r < 12'(`HOST_SETUP_CYC));
          if (cnt_r == 12'(3 * `HOST_SETUP_CYC))
          begin
            rsp_data  <= port.byte_data_lines;
            rsp_valid <= 1'b1;
            oe_n_r <= 1'b1;
            cs_n_r <= 1'b1;
            cnt_r  <= 12'h000;
            hs_r   <= HS_WAIT;
          end
        end
        HS_WAIT:
        begin
          // Allow the status delay and sync to settle before the next ready check
          if (cnt_r == 12'(`STATUS_DELAY_CYC + 4))
            hs_r <= HS_IDLE;
        end
        default:
          hs_r <= HS_IDLE;
      endcase
    end
  end

  assign port.chip_sel_n         = cs_n_r;
  assign port.out_gate_n         = oe_n_r;
  assign port.write_strobe_n     = we_n_r;
  assign port.addr_latch         = ale_r;
  assign port.muxed              = use_muxed;
  assign port.byte_address_lines = addr_r;
  assign port.host_data_out      = dout_r;
  assign port.host_data_oe       = doe_r;
  assign port.program_clock      = pclk_r;
endmodule
`default_nettype wire

// ==== eeprom_port_monitor.sv ====
// Purpose: Pin checks between host end and memory end
// Assumes: One clock, synchronous active-low reset
// Notes:   Memory end sees pins a few cycles late
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_port_params.svh"
module eeprom_port_monitor
  #(
    parameter int unsigned PROG_TICKS = `PROG_TICKS  // Program clock periods per interval
  )
  (
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    input wire logic                       chip_sel_n,
    input wire logic                       out_gate_n,
    input wire logic                       write_strobe_n,
    input wire logic                       addr_latch,
    input wire logic                       muxed,
    input wire logic                       host_data_oe,
    input wire logic                       mem_data_oe,
    input wire eeprom_port_pkg::byte_data_t mem_data_out,
    input wire eeprom_port_pkg::byte_addr_t addr_seen,
    input wire logic                       ready_busy,
    input wire logic                       program_clock
  );
  import eeprom_port_pkg::*;
  int unsigned tick_cnt_r;  // Program clock rises while busy
  int unsigned low_cnt_r;   // Cycles with write strobe low

  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Count program clock rises during the busy interval
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || ready_busy)
      tick_cnt_r <= 0;
    else if ($rose(program_clock))
      tick_cnt_r <= tick_cnt_r + 1;
  end

  // Measure each low pulse of the write strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || write_strobe_n)
      low_cnt_r <= 0;
    else
      low_cnt_r <= low_cnt_r + 1;
  end

  standby_no_drive_a: assert property (chip_sel_n [*5] |-> !mem_data_oe)
    else $error("memory drives bus while deselected");
  gate_release_a: assert property (out_gate_n [*5] |-> !mem_data_oe)
    else $error("memory drives bus with gate high");
  drive_when_ready_a: assert property (mem_data_oe |-> ready_busy)
    else $error("memory drives bus while busy");
  read_drives_a: assert property ((!chip_sel_n && !out_gate_n && write_strobe_n && ready_busy) [*6] |-> mem_data_oe)
    else $error("read mode without bus drive");
  data_hold_a: assert property ((mem_data_oe && $stable(addr_seen)) [*5] |-> $stable(mem_data_out))
    else $error("read byte changed with steady pins");
  busy_start_a: assert property ($rose(write_strobe_n) && !chip_sel_n && out_gate_n && ready_busy
    |-> ##[1:40] !ready_busy)
    else $error("status did not fall after program strobe");
  busy_holds_a: assert property ($fell(ready_busy) |-> !ready_busy [*8])
    else $error("status glitched high");
  prog_interval_a: assert property ($rose(ready_busy) |->
    tick_cnt_r + 1 >= PROG_TICKS && tick_cnt_r <= PROG_TICKS + 1)
    else $error("programming interval off");
  host_waits_a: assert property (!ready_busy [*4] |-> chip_sel_n && write_strobe_n)
    else $error("host active while busy");
  strobe_width_a: assert property ($rose(write_strobe_n) |->
    low_cnt_r >= `WE_MIN_CYC && low_cnt_r <= `WE_MAX_CYC)
    else $error("write strobe width out of range");
  mux_float_a: assert property ($fell(out_gate_n) && muxed |-> !host_data_oe)
    else $error("host drives bus as gate falls");
  read_strobes_a: assert property (!out_gate_n && !muxed |-> addr_latch && write_strobe_n)
    else $error("strobes low during read");
endmodule
`default_nettype wire

// ==== eeprom_byte_bus_port_bench.sv ====
// Purpose: Host end against memory end, separate and multiplexed
// Assumes: 200 MHz clock, short programming interval
// Notes:   Three program cycles dominate run time
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_port_params.svh"
`define CHECK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module eeprom_byte_bus_port_bench;
  import eeprom_port_pkg::*;
  localparam int unsigned TICKS = 4;                     // Shortened interval
  localparam int unsigned PERIOD = 2 * `PCLK_HALF_CYC;   // Program clock period
  logic       sys_clk;    // System clock
  logic       rst_n;      // Reset, active low
  logic       use_muxed;  // Address on data bus
  logic       req_valid;  // Request strobe
  logic       req_write;  // Program when high
  byte_addr_t req_addr;   // Target address
  byte_data_t req_data;   // Byte to program
  logic       req_ready;  // Request taken
  logic       rsp_valid;  // Read byte pulse
  byte_data_t rsp_data;   // Read byte
  logic       prog_busy;  // Memory sequencer busy
  port_mode_t mode_now;   // Decoded mode
  int         n_errors;   // Mismatches
  int         tests_run;  // Comparisons
  int         cycles;     // Run length

  eeprom_port_if bus (.sys_clk(sys_clk));
  eeprom_memory_end #(.PROG_TICKS(TICKS)) eeprom_memory_end_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .port(bus), .prog_busy(prog_busy), .mode_now(mode_now));
  eeprom_host_end eeprom_host_end_i (.sys_clk(sys_clk), .rst_n(rst_n), .port(bus),
    .use_muxed(use_muxed), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  eeprom_port_monitor #(.PROG_TICKS(TICKS)) eeprom_port_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .chip_sel_n(bus.chip_sel_n), .out_gate_n(bus.out_gate_n), .write_strobe_n(bus.write_strobe_n),
    .addr_latch(bus.addr_latch), .muxed(bus.muxed), .host_data_oe(bus.host_data_oe),
    .mem_data_oe(bus.mem_data_oe), .mem_data_out(bus.mem_data_out), .addr_seen(bus.addr_seen),
    .ready_busy(bus.ready_busy), .program_clock(bus.program_clock));

  // Clock toggles every half period
  always #2.5 sys_clk = ~sys_clk;

  // Report counts and verdict, then stop
  task automatic results;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      n_errors++;
      results();
    end
  end

  // Present one request and hold it until taken
  task automatic issue(input logic wr, input byte_addr_t a, input byte_data_t d, input logic mx);
    int w;
    @(posedge sys_clk);
    use_muxed <= mx;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_data  <= d;
    @(negedge sys_clk);
    for (w = 0; w < 200 && req_ready !== 1'b1; w++)
      @(negedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    `CHECK("request taken", 1'b1, w < 200)
  endtask

  // Program one byte and time the busy interval
  task automatic do_write(input byte_addr_t a, input byte_data_t d, input logic mx);
    int   w;
    int   low;
    logic seen_prog;
    logic rdy;
    seen_prog = 1'b0;
    rdy = 1'b0;
    low = 0;
    issue(1'b1, a, d, mx);
    for (w = 0; w < 300 && bus.ready_busy !== 1'b0; w++)
    begin
      @(negedge sys_clk);
      if (mode_now === MODE_PROGRAM)
        seen_prog = 1'b1;
    end
    `CHECK("status low", 1'b0, bus.ready_busy)
    `CHECK("busy flag", 1'b1, prog_busy)
    `CHECK("program mode", 1'b1, seen_prog)
    while (bus.ready_busy === 1'b0 && low < 30000)
    begin
      @(negedge sys_clk);
      low++;
      if (req_ready !== 1'b0)
        rdy = 1'b1;
    end
    `CHECK("interval min", 1'b1, low >= (TICKS - 1) * PERIOD)
    `CHECK("interval max", 1'b1, low <= (TICKS + 1) * PERIOD)
    `CHECK("held off", 1'b0, rdy)
  endtask

  // Read one byte and compare
  task automatic do_read(input byte_addr_t a, input logic mx, input byte_data_t exp);
    int   w;
    logic seen_read;
    seen_read = 1'b0;
    issue(1'b0, a, 8'h00, mx);
    for (w = 0; w < 100 && rsp_valid !== 1'b1; w++)
    begin
      @(negedge sys_clk);
      if (mode_now === MODE_READ)
        seen_read = 1'b1;
    end
    `CHECK("read answered", 1'b1, w < 100)
    `CHECK("read byte", exp, rsp_data)
    `CHECK("read mode", 1'b1, seen_read)
    `CHECK("read status", 1'b1, bus.ready_busy)
  endtask

  // Joined strobes: top address written and read back
  task automatic t_separate;
    do_write(7'h7f, 8'ha5, 1'b0);
    do_read(7'h7f, 1'b0, 8'ha5);
  endtask

  // Shared bus: address then data, read back on the shared bus with the byte written on separate lines
  task automatic t_muxed;
    do_write(7'h00, 8'h3c, 1'b1);
    do_read(7'h00, 1'b1, 8'h3c);
    do_read(7'h7f, 1'b1, 8'ha5);
  endtask

  // Overwrite, neighbour untouched, then idle in standby
  task automatic t_rewrite;
    do_write(7'h7f, 8'h5a, 1'b1);
    do_read(7'h7f, 1'b0, 8'h5a);
    do_read(7'h00, 1'b0, 8'h3c);
    repeat (10) @(negedge sys_clk);
    `CHECK("standby mode", MODE_STANDBY, mode_now)
    `CHECK("bus released", 1'b0, bus.mem_data_oe)
  endtask

  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    use_muxed = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 7'h00;
    req_data = 8'h00;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_separate();
    t_muxed();
    t_rewrite();
    results();
  end
endmodule
`default_nettype wire
